// ---- core/sysrst_pkg.sv ----
// package of constants and types for the system reset controller
//
// Overview of operation
// - system reset clears all but cause flags and brown-out enable
// - cause flags record latest reset source
// - low level on reset pin resets system
// - option byte reload causes full reset
// - either watchdog timeout causes system reset
// - software reset request bit causes reset
// - power on/down/brown-out reset whole system
// - non-power resets other than the pin reset drive reset pin low
// - processor fetches reset vector at 0x4
// - every internal reset lasts at least 40us
// - external pin low makes internal pulse
// - low supply detectors reset without help
// - brown-out reset disabled by default
// - brown-out enable only from option bytes
// - with brown-out on, hold until supply good
package sysrst_pkg;
    // clock and timing
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned MIN_PULSE_NS  = 40_000;
    localparam int unsigned MIN_PULSE_CYC = (MIN_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned CNT_W         = 12;

    // reset entry vector address
    localparam logic [31:0] RESET_VECTOR_ADDR = 32'h0000_0004;

    // register byte offsets
    localparam logic [7:0] CAUSE_OFS  = 8'h00;
    localparam logic [7:0] CTRL_OFS   = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] VECTOR_OFS = 8'h0c;

    // cause field positions
    localparam int unsigned PIN_BIT  = 0;
    localparam int unsigned OPT_BIT  = 1;
    localparam int unsigned WWD_BIT  = 2;
    localparam int unsigned IWD_BIT  = 3;
    localparam int unsigned SW_BIT   = 4;
    localparam int unsigned POR_BIT  = 5;
    localparam int unsigned BRN_BIT  = 6;
    localparam int unsigned CAUSE_W  = 7;

    // control field positions and cause reset value
    localparam int unsigned CLR_BIT   = 0;
    localparam int unsigned SWRQ_BIT  = 1;
    localparam logic [CAUSE_W-1:0] CAUSE_RST = 7'h20;

    // axi response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // stretcher states
    typedef enum logic [2:0] {
        ST_RUN  = 3'h1,
        ST_HOLD = 3'h2,
        ST_WAIT = 3'h4
    } sysrst_state_type;

    // raw reset requests
    typedef struct packed {
        logic bod;
        logic por;
        logic sw;
        logic iwd;
        logic wwd;
        logic opt;
        logic pin;
    } sysrst_req_type;
endpackage : sysrst_pkg

// ---- core/sysrst_sync.sv ----
// two-flop synchroniser for the external reset pin
`timescale 1ns/1ps
`default_nettype none
module sysrst_sync (
    // clock
    input  wire logic mclk,
    // async level in, synced level out
    input  wire logic d_in,
    output var  logic q_out
);
    logic meta_ff;

    // first flop feeds only the second; neither flop is reset, so q_out is unknown until two mclk edges have passed
    always_ff @(posedge mclk) begin
        meta_ff <= d_in;
        q_out   <= meta_ff;
    end
endmodule : sysrst_sync
`default_nettype wire

// ---- core/sysrst_top.sv ----
// system reset controller with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
module sysrst_top #(
    parameter int unsigned PULSE_CYC = sysrst_pkg::MIN_PULSE_CYC
) (
    // clock and power-level reset from the supply detectors
    input  wire logic        mclk,
    input  wire logic        rst,
    // reset pin, open drain: oe low means pin driven low
    input  wire logic        reset_pin_n_i,
    output var  logic        reset_pin_n_o,
    output var  logic        reset_pin_n_oe,
    // reset request sources
    input  wire logic        option_load_reset,
    input  wire logic        window_watchdog,
    input  wire logic        independent_watchdog,
    input  wire logic        power_down_detect,
    input  wire logic        brown_out_detect,
    input  wire logic        brown_opt_enable,
    // system reset out and boot vector
    output var  logic        sys_reset_ff,
    output var  logic [31:0] boot_vector_ff,
    // axi4-lite write address and data
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output var  logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output var  logic        wready,
    output var  logic [1:0]  bresp,
    output var  logic        bvalid,
    input  wire logic        bready,
    // axi4-lite read
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output var  logic        arready,
    output var  logic [31:0] rdata,
    output var  logic [1:0]  rresp,
    output var  logic        rvalid,
    input  wire logic        rready
);
    localparam int unsigned CW = sysrst_pkg::CNT_W;

    ////////////////////////////////////////////////////////////////////////////
    // requests
    logic                    pin_sync;
    logic                    brown_en_ff;
    logic                    sw_req_ff;
    logic                    aw_ok;
    logic                    w_ok;
    logic [7:0]              aw_ff;
    logic [31:0]             w_ff;
    logic [3:0]              ws_ff;
    logic [sysrst_pkg::CAUSE_W-1:0] cause_ff;
    logic [sysrst_pkg::CAUSE_W-1:0] nxt_cause;
    logic [CW-1:0]           cnt_ff;
    logic                    pin_src_ff;
    logic [1:0]              echo_ff;
    logic                    pin_mask;
    logic                    own_req;
    sysrst_pkg::sysrst_state_type st_ff;
    sysrst_pkg::sysrst_req_type   req;
    logic                    power_req;
    logic                    any_req;
    logic                    wr_go;

    sysrst_sync u_pin_sync (
        .mclk  (mclk),
        .d_in  (reset_pin_n_i),
        .q_out (pin_sync)
    );

    // our own pin drive echoes back through the synchroniser, so it is masked
    // while we drive and for the two cycles the release needs to come back;
    // an outside pull that starts inside the mask is seen once the mask ends
    assign pin_mask = pin_src_ff | (|echo_ff);

    // power detectors feed rst; the level is also sampled as a cause
    always_comb begin
        req.pin = ~pin_sync & ~pin_mask;
        req.opt = option_load_reset;
        req.wwd = window_watchdog;
        req.iwd = independent_watchdog;
        req.sw  = sw_req_ff;
        req.por = power_down_detect;
        req.bod = brown_en_ff & brown_out_detect;
    end
    assign power_req = req.por | req.bod;
    assign any_req   = |req;
    // a pin reset is not driven back: the outside party already holds the pin
    // low, and driving it ourselves would keep the request alive for ever
    assign own_req   = any_req & ~power_req & ~req.pin;

    ////////////////////////////////////////////////////////////////////////////
    // brown-out enable: reset default off, only loaded with option bytes
    // kept across system resets, since it stands for option-byte state
    always_ff @(posedge mclk) begin
        if (rst) begin
            brown_en_ff <= 1'b0;
        end else if (option_load_reset) begin
            brown_en_ff <= brown_opt_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // stretcher: hold reset while any request, then at least PULSE_CYC more
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_ff  <= sysrst_pkg::ST_HOLD;
            cnt_ff <= '0;
        end else begin
            case (st_ff)
                sysrst_pkg::ST_RUN: begin
                    if (any_req) begin
                        st_ff  <= sysrst_pkg::ST_HOLD;
                        cnt_ff <= '0;
                    end
                end
                sysrst_pkg::ST_HOLD: begin
                    if (any_req) begin
                        cnt_ff <= '0;
                    end else begin
                        st_ff  <= sysrst_pkg::ST_WAIT;
                        cnt_ff <= CW'(1);
                    end
                end
                sysrst_pkg::ST_WAIT: begin
                    if (any_req) begin
                        st_ff  <= sysrst_pkg::ST_HOLD;
                        cnt_ff <= '0;
                    end else if (cnt_ff >= CW'(PULSE_CYC)) begin
                        st_ff <= sysrst_pkg::ST_RUN;
                    end else begin
                        cnt_ff <= cnt_ff + CW'(1);
                    end
                end
                default: begin
                    st_ff  <= sysrst_pkg::ST_HOLD;
                    cnt_ff <= '0;
                end
            endcase
        end
    end

    // reset out, pin drive and vector; pin source masks own echo
    always_ff @(posedge mclk) begin
        if (rst) begin
            sys_reset_ff   <= 1'b1;
            reset_pin_n_o  <= 1'b0;
            reset_pin_n_oe <= 1'b1; // power reset leaves the pin alone
            pin_src_ff     <= 1'b0;
            echo_ff        <= 2'b00;
            boot_vector_ff <= sysrst_pkg::RESET_VECTOR_ADDR;
        end else begin
            sys_reset_ff   <= (st_ff != sysrst_pkg::ST_RUN) | any_req;
            reset_pin_n_o  <= 1'b0; // open drain: only ever pulls low
            reset_pin_n_oe <= ~(own_req |
                              ((st_ff != sysrst_pkg::ST_RUN) & pin_src_ff));
            pin_src_ff     <= own_req |
                              (pin_src_ff & (st_ff != sysrst_pkg::ST_RUN));
            // the released pin needs two more cycles to come back through the synchroniser
            echo_ff        <= {echo_ff[0], pin_src_ff};
            boot_vector_ff <= sysrst_pkg::RESET_VECTOR_ADDR;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // cause flags: rst loads por alone; power_down_detect also sets por
    always_comb begin
        nxt_cause = cause_ff;
        if (wr_go && aw_ff == sysrst_pkg::CTRL_OFS && ws_ff[0] && w_ff[sysrst_pkg::CLR_BIT]) begin
            nxt_cause = '0;
        end
        if (st_ff == sysrst_pkg::ST_RUN && any_req) begin
            nxt_cause = req; // latest source replaces older ones
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            cause_ff <= sysrst_pkg::CAUSE_RST;
        end else begin
            cause_ff <= nxt_cause; // set wins over clear
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite write: take aw and w in any order, answer after both
    assign wr_go = aw_ok & w_ok & ~bvalid;
    always_ff @(posedge mclk) begin
        if (rst | sys_reset_ff) begin
            aw_ok   <= 1'b0;
            w_ok    <= 1'b0;
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= sysrst_pkg::RESP_OKAY;
            aw_ff   <= '0;
            w_ff    <= '0;
            ws_ff   <= '0;
            sw_req_ff <= 1'b0;
        end else begin
            awready <= ~aw_ok & ~awready & awvalid;
            wready  <= ~w_ok & ~wready & wvalid;
            if (awvalid & awready) begin
                aw_ok <= 1'b1;
                aw_ff <= awaddr;
            end
            if (wvalid & wready) begin
                w_ok  <= 1'b1;
                w_ff  <= wdata;
                ws_ff <= wstrb;
            end
            if (wr_go) begin
                aw_ok  <= 1'b0;
                w_ok   <= 1'b0;
                bvalid <= 1'b1;
                bresp  <= (aw_ff == sysrst_pkg::CTRL_OFS || aw_ff == sysrst_pkg::CAUSE_OFS)
                          ? sysrst_pkg::RESP_OKAY : sysrst_pkg::RESP_SLVERR;
                if (aw_ff == sysrst_pkg::CTRL_OFS && ws_ff[0] && w_ff[sysrst_pkg::SWRQ_BIT]) begin
                    sw_req_ff <= 1'b1;
                end
            end else if (bvalid & bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // axi4-lite read: one cycle after address accepted
    always_ff @(posedge mclk) begin
        if (rst | sys_reset_ff) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= sysrst_pkg::RESP_OKAY;
        end else begin
            arready <= ~arready & ~rvalid & arvalid;
            if (arvalid & arready) begin
                rvalid <= 1'b1;
                rresp  <= sysrst_pkg::RESP_OKAY;
                case (araddr)
                    sysrst_pkg::CAUSE_OFS:  rdata <= {25'h0, cause_ff};
                    sysrst_pkg::CTRL_OFS:   rdata <= 32'h0;
                    sysrst_pkg::STATUS_OFS: rdata <= {31'h0, brown_en_ff};
                    sysrst_pkg::VECTOR_OFS: rdata <= boot_vector_ff;
                    default: begin
                        rdata <= 32'h0;
                        rresp <= sysrst_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (rvalid & rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    int unsigned low_cnt;
    always_ff @(posedge mclk) begin
        if (rst | ~sys_reset_ff) begin
            low_cnt <= 0;
        end else if (low_cnt < 32'hffff) begin
            low_cnt <= low_cnt + 1;
        end
    end

    sequence req_seen_s;
        any_req && st_ff == sysrst_pkg::ST_RUN;
    endsequence
    sequence reset_out_s;
        ##1 sys_reset_ff;
    endsequence

    stretch_min_a : assert property (@(posedge mclk) disable iff (rst)
        $fell(sys_reset_ff) |-> $past(low_cnt) >= PULSE_CYC)
        else $error("reset pulse shorter than minimum");
    req_reset_a : assert property (@(posedge mclk) disable iff (rst)
        req_seen_s |-> reset_out_s)
        else $error("request did not raise system reset");
    cause_rec_a : assert property (@(posedge mclk) disable iff (rst)
        req_seen_s |=> cause_ff == $past(req))
        else $error("cause flags not recorded");
    pin_drive_a : assert property (@(posedge mclk) disable iff (rst)
        (st_ff == sysrst_pkg::ST_RUN && (req.wwd || req.iwd || req.opt || req.sw) && !power_req)
        |=> !reset_pin_n_oe)
        else $error("reset pin not driven for internal reset");
    pin_reset_a : assert property (@(posedge mclk) disable iff (rst)
        (st_ff == sysrst_pkg::ST_RUN && !reset_pin_n_i && !pin_src_ff) |-> ##[2:3] sys_reset_ff)
        else $error("pin low did not reset");
    brown_off_a : assert property (@(posedge mclk) disable iff (rst)
        (st_ff == sysrst_pkg::ST_RUN && !brown_en_ff && brown_out_detect &&
         !(req.pin || req.opt || req.wwd || req.iwd || req.sw || req.por)) |=> !sys_reset_ff)
        else $error("brown-out reset while disabled");
    brown_opt_a : assert property (@(posedge mclk) disable iff (rst)
        !option_load_reset |=> $stable(brown_en_ff))
        else $error("brown-out enable changed outside option load");
    pin_echo_a : assert property (@(posedge mclk) disable iff (rst)
        $rose(reset_pin_n_oe) |-> (!req.pin) [*2])
        else $error("own pin release seen as pin reset");
    vector_a : assert property (@(posedge mclk) disable iff (rst)
        $fell(sys_reset_ff) |-> boot_vector_ff == sysrst_pkg::RESET_VECTOR_ADDR)
        else $error("wrong reset vector");
endmodule : sysrst_top
`default_nettype wire

// ---- tb/sysrst_pin_model.sv ----
// behavioural model of the reset pin wiring with its pull-up
`timescale 1ns/1ps
`default_nettype none
module sysrst_pin_model (
    // outside party pulling the pin low
    input  wire logic ext_low,
    // device open-drain drive
    input  wire logic pin_o,
    input  wire logic pin_oe,
    // resolved pin level
    output var  logic pin_n
);
    // pull-up holds the pin high only when nobody pulls it low
    always_comb begin
        pin_n = 1'b1;
        if (ext_low) pin_n = 1'b0;
        else if (!pin_oe) pin_n = pin_o;
    end
endmodule : sysrst_pin_model
`default_nettype wire

// ---- tb/system_reset_controller_tb.sv ----
// self-checking bench for the system reset controller
`timescale 1ns/1ps
`default_nettype none
module system_reset_controller_tb;
    localparam int P = 8;
    logic        mclk, rst, pin_n, oe, pin_o, sys_rst;
    logic [5:0]  req;
    logic        brown_en, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] bootv, wdata, rdata, d;
    logic [7:0]  awaddr, araddr;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    logic [15:0] lf;
    int          n_errors, check_count, hi, lo, len, s;
    int          cpos[6] = '{sysrst_pkg::PIN_BIT, sysrst_pkg::OPT_BIT, sysrst_pkg::WWD_BIT,
                             sysrst_pkg::IWD_BIT, sysrst_pkg::POR_BIT, sysrst_pkg::BRN_BIT};

    sysrst_top #(.PULSE_CYC(P)) dut (.mclk(mclk), .rst(rst), .reset_pin_n_i(pin_n), .reset_pin_n_o(pin_o),
        .reset_pin_n_oe(oe), .option_load_reset(req[1]), .window_watchdog(req[2]),
        .independent_watchdog(req[3]), .power_down_detect(req[4]), .brown_out_detect(req[5]),
        .brown_opt_enable(brown_en), .sys_reset_ff(sys_rst), .boot_vector_ff(bootv),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));
    sysrst_pin_model pm (.ext_low(req[0]), .pin_o(pin_o), .pin_oe(oe), .pin_n(pin_n));

    // 50 MHz clock
    always #10 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////
    function logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr

    function logic [31:0] cbit(input int b);
        return 32'h1 << b;
    endfunction : cbit

    task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %0t %s: saw %h want %h", $time, m, seen, exp);
        end
    endtask : chk

    task done(input string t);
        $display("test %s ended", t);
    endtask : done

    // write; both channels offered together, each released once taken, then wait for the response
    task axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        bit dn;
        @(posedge mclk);
        awaddr <= a; wdata <= v; wstrb <= 4'hf;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge mclk);
            dn = (bvalid === 1'b1);
            if (dn || awready === 1'b1) awvalid <= 1'b0;
            if (dn || wready === 1'b1) wvalid <= 1'b0;
        end while (!dn);
        rs = bresp;
        bready <= 1'b0;
    endtask : axw

    task axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge mclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        v = rdata; rs = rresp;
        rready <= 1'b0;
    endtask : axr

    task rdc(input logic [7:0] a, input logic [31:0] e, input string m);
        logic [31:0] v;
        logic [1:0]  rs;
        axr(a, v, rs);
        chk({30'h0, rs}, {30'h0, sysrst_pkg::RESP_OKAY}, m);
        chk(v, e, m);
    endtask : rdc

    // counts reset cycles and the cycles of them with the pin driven
    task measure(output int h, output int l);
        int k;
        h = 0; l = 0; k = 0;
        while (sys_rst !== 1'b1 && k < 10) begin @(posedge mclk); k++; end
        while (sys_rst === 1'b1 && h < 5000) begin
            if (oe === 1'b0) l++;
            h++;
            @(posedge mclk);
        end
    endtask : measure

    task fire(input int i, input int n, output int h, output int l);
        fork
            begin @(posedge mclk); req[i] <= 1'b1; repeat (n) @(posedge mclk); req[i] <= 1'b0; end
            measure(h, l);
        join
    endtask : fire

    task complete_run;
        $display("comparisons %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////////////////////
    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (6000) @(posedge mclk);
        n_errors++;
        $display("FAIL %0t run hung", $time);
        complete_run();
    end

    // main sequence
    initial begin
        mclk = 0; rst = 1; req = 0; brown_en = 0; awaddr = 0; araddr = 0; wdata = 0; wstrb = 0;
        awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        lf = 16'h0134; n_errors = 0; check_count = 0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        measure(hi, lo);
        chk(32'(hi >= P), 1, "power-up stretch");
        chk(lo, 0, "pin driven on power reset");
        rdc(sysrst_pkg::CAUSE_OFS, cbit(sysrst_pkg::POR_BIT), "power cause");
        rdc(sysrst_pkg::VECTOR_OFS, sysrst_pkg::RESET_VECTOR_ADDR, "vector reg");
        chk(bootv, sysrst_pkg::RESET_VECTOR_ADDR, "boot vector");
        rdc(sysrst_pkg::STATUS_OFS, 0, "brown-out default");
        axr(8'h10, d, r);
        chk({30'h0, r}, {30'h0, sysrst_pkg::RESP_SLVERR}, "unmapped read");
        axw(8'h14, {16'h0, lf}, r);
        chk({30'h0, r}, {30'h0, sysrst_pkg::RESP_SLVERR}, "unmapped write");
        done("power-up and map");
        // brown-out request ignored while disabled, status not writable
        req[5] <= 1'b1;
        repeat (6) @(posedge mclk);
        chk(sys_rst, 0, "brown-out while off");
        req[5] <= 1'b0;
        axw(sysrst_pkg::STATUS_OFS, 32'h1, r);
        rdc(sysrst_pkg::STATUS_OFS, 0, "status write");
        done("brown-out off");
        // every non-brown-out source but software reset, in order then in random order, short random requests
        for (int k = 0; k < 10; k++) begin
            lf = lfsr(lf);
            s = (k < 5) ? k : int'(lf[7:4]) % 5;
            len = 1 + int'(lf[1:0]);
            fire(s, len, hi, lo);
            chk(32'(hi >= P && hi >= len), 1, "stretch");
            chk(lo, (s == 0 || s == 4) ? 0 : hi, "pin drive");
            rdc(sysrst_pkg::CAUSE_OFS, cbit(cpos[s]), "cause");
        end
        done("sources");
        // software reset, then the request bit must not fire again
        axw(sysrst_pkg::CTRL_OFS, 32'h2, r);
        measure(hi, lo);
        chk(32'(hi >= P && lo == hi), 1, "sw reset pulse");
        rdc(sysrst_pkg::CAUSE_OFS, cbit(sysrst_pkg::SW_BIT), "sw cause");
        repeat (P + 4) @(posedge mclk);
        chk(sys_rst, 0, "sw bit cleared by reset");
        axw(sysrst_pkg::CTRL_OFS, 32'h1, r);
        rdc(sysrst_pkg::CAUSE_OFS, 0, "cause clear");
        done("software reset");
        // brown-out enabled by option load, then holds reset while low supply lasts
        brown_en <= 1'b1;
        fire(1, 2, hi, lo);
        brown_en <= 1'b0;
        rdc(sysrst_pkg::STATUS_OFS, 1, "brown-out enabled");
        fire(5, 12, hi, lo);
        chk(32'(hi >= 12 && lo == 0), 1, "brown-out hold");
        rdc(sysrst_pkg::CAUSE_OFS, cbit(sysrst_pkg::BRN_BIT), "brown-out cause");
        done("brown-out on");
        complete_run();
    end
endmodule : system_reset_controller_tb
`default_nettype wire
